// [hw/eirq_pkg.sv]
// package: register map, fields, reset values for external irq detect block
package eirq_pkg;
    localparam int          NUM_PINS        = 6;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  OFS_SENSE       = 4'h0;
    localparam logic [3:0]  OFS_FLAGS       = 4'h1;
    localparam logic [3:0]  OFS_ENABLES     = 4'h2;
    localparam logic [3:0]  OFS_PRIO_LO     = 4'h3;
    localparam logic [3:0]  OFS_PRIO_HI     = 4'h4;
    localparam logic [3:0]  OFS_SYSCTL      = 4'h5;
    localparam logic [3:0]  OFS_INT_STATUS  = 4'h6;
    localparam logic [3:0]  OFS_INT_MASK    = 4'h7;
    localparam logic [15:0] RST_SENSE       = 16'h0000;
    localparam logic [7:0]  RST_FLAGS       = 8'h00;
    localparam logic [7:0]  RST_ENABLES     = 8'h00;
    localparam logic [2:0]  RST_PRIO        = 3'h7;
    localparam logic [7:0]  RST_INT         = 8'h00;
    localparam int          SENSE_W         = 2;
    localparam int          PRIO_W          = 3;
    localparam int          PRIO_STRIDE     = 4;
    localparam int          NMI_EDGE_BIT    = 0;
    localparam int          INT_NMI_BIT     = 6;
    localparam int          INT_WAKE_BIT    = 7;
    typedef enum logic [1:0] {
        EIRQ_SENSE_LOW  = 2'h0,
        EIRQ_SENSE_FALL = 2'h1,
        EIRQ_SENSE_RISE = 2'h2,
        EIRQ_SENSE_BOTH = 2'h3
    } eirq_sense_t;
endpackage

// [hw/eirq_sync.sv]
// module: two-flop synchroniser with edge sample stage
`timescale 1ns/1ps
module eirq_sync
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    // pin
    input  wire logic pin_in,
    // synchronised level and previous sample
    output logic      level_out,
    output logic      prev_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end
        else if (ce_in)
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign prev_out  = prev_q;
endmodule

// [hw/eirq_pin_detect.sv]
// module: per-pin sense decode producing a one-cycle set pulse on edges, held high while the pin is low in low-level mode
`timescale 1ns/1ps
module eirq_pin_detect
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // pin and mode
    input  wire logic       pin_in,
    input  wire logic [1:0] sense_in,
    // outputs
    output logic            set_out,
    output logic            level_out
);
    logic lvl;
    logic prv;
    logic fall;
    logic rise;

    eirq_sync u_sync
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .pin_in    (pin_in),
        .level_out (lvl),
        .prev_out  (prv)
    );

    assign fall      = prv & ~lvl;
    assign rise      = ~prv & lvl;
    assign level_out = lvl;

    always_comb
    begin
        case (eirq_pkg::eirq_sense_t'(sense_in))
            eirq_pkg::EIRQ_SENSE_LOW:  set_out = ~lvl;
            eirq_pkg::EIRQ_SENSE_FALL: set_out = fall;
            eirq_pkg::EIRQ_SENSE_RISE: set_out = rise;
            eirq_pkg::EIRQ_SENSE_BOTH: set_out = fall | rise;
            default:                   set_out = 1'b0;
        endcase
    end
endmodule

// [hw/eirq_top.sv]
// module: external interrupt detect, status, enable and priority front end
// Summary of operation
// - sense 00 low, 01 fall, 10 rise, 11 both
// - sense register sixteen bits, two per pin
// - detection sets pin status flag
// - flag clears on zero write after read-one
// - low-level flag auto-clears on exception handling when pin high
// - edge flag auto-clears on exception handling
// - nonmaskable request always accepted, top priority
// - nonmaskable edge chosen by control bit
// - per-pin enable gates request forwarding
// - each pin request carries priority level
// - detection independent of port direction
// - any external request wakes from standby
// - peripheral request needs flag and enable
// - enable bits reset zero, one permits
// - priority fields three bits, 7 highest
`timescale 1ns/1ps
module eirq_top
#(
    parameter int NUM_PERIPH = 4
)
(
    // clock, reset, enable
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  ce_in,
    // external pins
    input  wire logic [5:0]            irq_pins_in,
    input  wire logic                  nmi_pin_in,
    // exception handling acknowledge, one pulse per pin
    input  wire logic [5:0]            exc_ack_in,
    // on-chip peripheral sources
    input  wire logic [NUM_PERIPH-1:0] periph_flag_in,
    input  wire logic [NUM_PERIPH-1:0] periph_en_in,
    // register port
    input  wire logic [3:0]            addr_in,
    input  wire logic [15:0]           wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic [15:0]                rdata_out,
    // requests to cpu
    output logic [5:0]                 pin_req_out,
    output logic [17:0]                pin_prio_out,
    output logic                       nmi_req_out,
    output logic [NUM_PERIPH-1:0]      periph_req_out,
    output logic                       wake_out,
    output logic                       irq_out
);
    // elaboration check on peripheral count
    if (NUM_PERIPH < 1 || NUM_PERIPH > 16)
    begin : g_bad_periph
        $error("NUM_PERIPH out of range");
    end

    localparam int NP = eirq_pkg::NUM_PINS;

    logic [15:0]   sense_q;
    logic [7:0]    flags_q;
    logic [7:0]    flags_d;
    logic [7:0]    enables_q;
    logic [NP-1:0] read_one_q;
    logic [NP-1:0] read_one_d;
    logic [23:0]   prio_q;
    logic          nmi_edge_q;
    logic [7:0]    int_status_q;
    logic [7:0]    int_status_d;
    logic [7:0]    int_mask_q;
    logic [NP-1:0] set_pulse;
    logic [NP-1:0] pin_level;
    logic          nmi_lvl;
    logic          nmi_prv;
    logic          nmi_event;
    logic [NP-1:0] req_now;

    // per-pin detectors, pins sampled regardless of port direction
    genvar g;
    generate
        for (g = 0; g < NP; g++)
        begin : g_pin
            eirq_pin_detect u_det
            (
                .clk_in    (clk_in),
                .rst_in    (rst_in),
                .ce_in     (ce_in),
                .pin_in    (irq_pins_in[g]),
                .sense_in  (sense_q[2*g+1:2*g]),
                .set_out   (set_pulse[g]),
                .level_out (pin_level[g])
            );
        end
    endgenerate

    eirq_sync u_nmi_sync
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .pin_in    (nmi_pin_in),
        .level_out (nmi_lvl),
        .prev_out  (nmi_prv)
    );

    // rising when select bit one, else falling
    assign nmi_event = nmi_edge_q ? (~nmi_prv & nmi_lvl) : (nmi_prv & ~nmi_lvl);

    logic wr_sense;
    logic wr_flags;
    logic rd_flags;
    logic wr_enables;
    logic wr_prio_lo;
    logic wr_prio_hi;
    logic wr_sysctl;
    logic wr_mask;
    assign wr_sense   = wr_in && addr_in == eirq_pkg::OFS_SENSE;
    assign wr_flags   = wr_in && addr_in == eirq_pkg::OFS_FLAGS;
    assign rd_flags   = rd_in && addr_in == eirq_pkg::OFS_FLAGS;
    assign wr_enables = wr_in && addr_in == eirq_pkg::OFS_ENABLES;
    assign wr_prio_lo = wr_in && addr_in == eirq_pkg::OFS_PRIO_LO;
    assign wr_prio_hi = wr_in && addr_in == eirq_pkg::OFS_PRIO_HI;
    assign wr_sysctl  = wr_in && addr_in == eirq_pkg::OFS_SYSCTL;
    assign wr_mask    = wr_in && addr_in == eirq_pkg::OFS_INT_MASK;

    // sense selection, reserved upper bits kept zero
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sense_q <= eirq_pkg::RST_SENSE;
        end
        else if (ce_in && wr_sense)
        begin
            sense_q <= {4'h0, wdata_in[11:0]};
        end
    end

    // pin enables, reserved bits kept zero
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            enables_q <= eirq_pkg::RST_ENABLES;
        end
        else if (ce_in && wr_enables)
        begin
            enables_q <= {2'h0, wdata_in[5:0]};
        end
    end

    // priority fields, top bit of each nibble held zero
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prio_q <= {6{1'b0, eirq_pkg::RST_PRIO}};
        end
        else if (ce_in && wr_prio_lo)
        begin
            prio_q[15:0] <= wdata_in & 16'h7777;
        end
        else if (ce_in && wr_prio_hi)
        begin
            prio_q[23:16] <= wdata_in[7:0] & 8'h77;
        end
    end

    // nonmaskable edge select
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            nmi_edge_q <= 1'b0;
        end
        else if (ce_in && wr_sysctl)
        begin
            nmi_edge_q <= wdata_in[eirq_pkg::NMI_EDGE_BIT];
        end
    end

    // interrupt mask
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            int_mask_q <= eirq_pkg::RST_INT;
        end
        else if (ce_in && wr_mask)
        begin
            int_mask_q <= wdata_in[7:0];
        end
    end

    // status flags: set, read-one-then-write-zero clear, auto clear
    always_comb
    begin
        flags_d    = flags_q;
        read_one_d = read_one_q;
        for (int i = 0; i < NP; i++)
        begin
            if (rd_flags && flags_q[i])
            begin
                read_one_d[i] = 1'b1;
            end
            if (wr_flags && !wdata_in[i] && read_one_q[i])
            begin
                flags_d[i]    = 1'b0;
                read_one_d[i] = 1'b0;
            end
            if (exc_ack_in[i])
            begin
                if (sense_q[2*i +: 2] != eirq_pkg::EIRQ_SENSE_LOW)
                begin
                    flags_d[i] = 1'b0;
                end
                else if (pin_level[i])
                begin
                    flags_d[i] = 1'b0;
                end
            end
            if (set_pulse[i])
            begin
                flags_d[i] = 1'b1;
            end
            if (!flags_d[i])
            begin
                read_one_d[i] = 1'b0;
            end
        end
        flags_d[7:6] = 2'h0;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            flags_q    <= eirq_pkg::RST_FLAGS;
            read_one_q <= '0;
        end
        else if (ce_in)
        begin
            flags_q    <= flags_d;
            read_one_q <= read_one_d;
        end
    end

    // interrupt status: pin events, nmi event, wake
    assign req_now = flags_q[NP-1:0] & enables_q[NP-1:0];

    always_comb
    begin
        int_status_d = int_status_q;
        if (wr_in && addr_in == eirq_pkg::OFS_INT_STATUS)
        begin
            int_status_d = int_status_q & ~wdata_in[7:0];
        end
        int_status_d[NP-1:0] = int_status_d[NP-1:0] | set_pulse;
        int_status_d[eirq_pkg::INT_NMI_BIT] = int_status_d[eirq_pkg::INT_NMI_BIT] | nmi_event;
        int_status_d[eirq_pkg::INT_WAKE_BIT] = int_status_d[eirq_pkg::INT_WAKE_BIT]
                                             | (|set_pulse) | nmi_event;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            int_status_q <= eirq_pkg::RST_INT;
        end
        else if (ce_in)
        begin
            int_status_q <= int_status_d;
        end
    end

    // registered outputs to cpu
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_req_out    <= '0;
            pin_prio_out   <= '0;
            nmi_req_out    <= 1'b0;
            periph_req_out <= '0;
            wake_out       <= 1'b0;
            irq_out        <= 1'b0;
        end
        else if (ce_in)
        begin
            pin_req_out    <= req_now;
            for (int i = 0; i < NP; i++)
            begin
                pin_prio_out[3*i +: 3] <= prio_q[4*i +: 3];
            end
            nmi_req_out    <= nmi_event;
            periph_req_out <= periph_flag_in & periph_en_in;
            wake_out       <= nmi_event | (|req_now);
            irq_out        <= |(int_status_d & int_mask_q);
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_out <= 16'h0000;
        end
        else if (ce_in)
        begin
            rdata_out <= 16'h0000;
            if (rd_in)
            begin
                case (addr_in)
                    eirq_pkg::OFS_SENSE:      rdata_out <= sense_q;
                    eirq_pkg::OFS_FLAGS:      rdata_out <= {8'h00, flags_q};
                    eirq_pkg::OFS_ENABLES:    rdata_out <= {8'h00, enables_q};
                    eirq_pkg::OFS_PRIO_LO:    rdata_out <= prio_q[15:0];
                    eirq_pkg::OFS_PRIO_HI:    rdata_out <= {8'h00, prio_q[23:16]};
                    eirq_pkg::OFS_SYSCTL:     rdata_out <= {15'h0000, nmi_edge_q};
                    eirq_pkg::OFS_INT_STATUS: rdata_out <= {8'h00, int_status_q};
                    eirq_pkg::OFS_INT_MASK:   rdata_out <= {8'h00, int_mask_q};
                    default:                  rdata_out <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// [dv/eirq_top_properties.sv]
// checker: port-level properties of the external irq front end
`timescale 1ns/1ps
module eirq_top_properties
#(
    parameter int NUM_PERIPH = 4
)
(
    // clock, reset, inputs
    input wire logic                  clk_in,
    input wire logic                  rst_in,
    input wire logic                  nmi_pin_in,
    input wire logic [NUM_PERIPH-1:0] periph_flag_in,
    input wire logic [NUM_PERIPH-1:0] periph_en_in,
    input wire logic [3:0]            addr_in,
    input wire logic                  rd_in,
    // outputs watched
    input wire logic [15:0]           rdata_out,
    input wire logic [5:0]            pin_req_out,
    input wire logic                  nmi_req_out,
    input wire logic [NUM_PERIPH-1:0] periph_req_out,
    input wire logic                  wake_out,
    input wire logic                  irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside read slot");
    sense_rsvd_a: assert property ($past(rd_in) && $past(addr_in) == eirq_pkg::OFS_SENSE
        |-> rdata_out[15:12] == 4'h0) else $error("sense reserved bits set");
    flag_rsvd_a: assert property ($past(rd_in) && $past(addr_in) == eirq_pkg::OFS_FLAGS
        |-> rdata_out[15:6] == 10'h000) else $error("flag reserved bits set");
    enable_rsvd_a: assert property ($past(rd_in) && $past(addr_in) == eirq_pkg::OFS_ENABLES
        |-> rdata_out[15:6] == 10'h000) else $error("enable reserved bits set");
    unmapped_rd_a: assert property ($past(rd_in) && $past(addr_in) > 4'h7
        |-> rdata_out == 16'h0000) else $error("unmapped read not zero");
    periph_req_a: assert property (periph_req_out == $past(periph_flag_in & periph_en_in))
        else $error("peripheral request mismatch");
    nmi_pulse_a: assert property (nmi_req_out |=> !nmi_req_out)
        else $error("nmi request longer than one cycle");
    nmi_cause_a: assert property (nmi_req_out |-> $past(nmi_pin_in, 2) != $past(nmi_pin_in, 5))
        else $error("nmi request without pin edge");
    wake_req_a: assert property (|pin_req_out |-> ##[0:2] wake_out)
        else $error("pin request without wake");
    reset_quiet_a: assert property ($fell(rst_in) |-> pin_req_out == 6'h00 && !irq_out)
        else $error("outputs active after reset");
endmodule

bind eirq_top eirq_top_properties #(.NUM_PERIPH(NUM_PERIPH)) eirq_top_properties_i (.*);

// [dv/eirq_pin_model.sv]
// partner: external devices driving the request pins
`timescale 1ns/1ps
module eirq_pin_model
(
    // clock and commanded levels
    input  wire logic       clk_in,
    input  wire logic [5:0] lvl_in,
    input  wire logic       nmi_lvl_in,
    // pins
    output logic [5:0]      irq_pins_out,
    output logic            nmi_pin_out
);
    initial
    begin
        irq_pins_out = 6'h3F;
        nmi_pin_out  = 1'b1;
    end
    // pins used as interrupt inputs only, driven as plain levels
    always @(posedge clk_in)
    begin
        irq_pins_out <= lvl_in;
        nmi_pin_out  <= nmi_lvl_in;
    end
endmodule

// [dv/test_external_irq_detect_status.sv]
// testbench: registers, detection, clearing, nmi and interrupt scenarios
`timescale 1ns/1ps
module test_external_irq_detect_status;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic [5:0]  lvl = 6'h3F;
    logic        nmi_lvl = 1'b1;
    logic [5:0]  irq_pins_in;
    logic        nmi_pin_in;
    logic [5:0]  exc_ack_in = 6'h00;
    logic [3:0]  periph_flag_in = 4'h0;
    logic [3:0]  periph_en_in = 4'h0;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [15:0] rdata_out;
    logic [5:0]  pin_req_out;
    logic [17:0] pin_prio_out;
    logic        nmi_req_out;
    logic [3:0]  periph_req_out;
    logic        wake_out;
    logic        irq_out;
    logic [15:0] rv;
    int          n_errors = 0;
    int          num_checks = 0;

    eirq_pin_model eirq_pin_model_i (.clk_in(clk_in), .lvl_in(lvl), .nmi_lvl_in(nmi_lvl),
        .irq_pins_out(irq_pins_in), .nmi_pin_out(nmi_pin_in));
    eirq_top eirq_top_i (.*);

    initial
        forever #12.5 clk_in = ~clk_in;

    task automatic tally_and_finish;
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rv = rdata_out;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        rd(a);
        chk(rv, e);
    endtask
    task automatic pins(input logic [5:0] v);
        @(posedge clk_in);
        lvl <= v;
        repeat (7) @(posedge clk_in);
    endtask
    task automatic exc(input logic [5:0] v);
        @(posedge clk_in);
        exc_ack_in <= v;
        @(posedge clk_in);
        exc_ack_in <= 6'h00;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic nmi_edge(input logic v, input int exp);
        int c;
        int w;
        c = 0;
        w = 0;
        @(posedge clk_in);
        nmi_lvl <= v;
        repeat (7)
        begin
            @(posedge clk_in);
            #1;
            if (nmi_req_out === 1'b1) c++;
            if (wake_out === 1'b1) w++;
        end
        chk(18'(c), 18'(exp));
        chk(18'(w), 18'(exp));
    endtask

    // reset values, reserved bits, unmapped index, priorities
    task automatic t_regs;
        logic [15:0] e [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h7777,
                               16'h0077, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 8; i++)
            rchk(4'(i), e[i]);
        chk(pin_prio_out, 18'h3_FFFF);
        wr(eirq_pkg::OFS_SENSE, 16'h0FFF);
        rchk(eirq_pkg::OFS_SENSE, 16'h0FFF);
        wr(eirq_pkg::OFS_ENABLES, 16'h003F);
        rchk(eirq_pkg::OFS_ENABLES, 16'h003F);
        wr(4'hF, 16'hFFFF);
        rchk(4'hF, 16'h0000);
        wr(eirq_pkg::OFS_PRIO_LO, 16'h0123);
        wr(eirq_pkg::OFS_PRIO_HI, 16'h0065);
        rchk(eirq_pkg::OFS_PRIO_LO, 16'h0123);
        chk(pin_prio_out, 18'h3_5053);
    endtask
    // all four sense codes, enable gating, read-then-zero clearing
    task automatic t_sense;
        wr(eirq_pkg::OFS_SENSE, 16'h09E4);
        wr(eirq_pkg::OFS_ENABLES, 16'h0015);
        pins(6'h00);
        rchk(eirq_pkg::OFS_FLAGS, 16'h001B);
        chk(pin_req_out, 6'h11);
        wr(eirq_pkg::OFS_FLAGS, 16'h0000);
        rchk(eirq_pkg::OFS_FLAGS, 16'h0001);
        pins(6'h3F);
        wr(eirq_pkg::OFS_FLAGS, 16'h0000);
        rd(eirq_pkg::OFS_FLAGS);
        chk(rv[5:2], 4'hB);
        wr(eirq_pkg::OFS_FLAGS, 16'h0000);
        rchk(eirq_pkg::OFS_FLAGS, 16'h0000);
    endtask
    // automatic clearing by exception handling
    task automatic t_exc;
        pins(6'h00);
        exc(6'h3F);
        rchk(eirq_pkg::OFS_FLAGS, 16'h0001);
        pins(6'h3F);
        exc(6'h01);
        rchk(eirq_pkg::OFS_FLAGS, 16'h002C);
        wr(eirq_pkg::OFS_FLAGS, 16'h0000);
    endtask
    // nonmaskable edge select, both polarities, mask left clear
    task automatic t_nmi;
        nmi_edge(1'b0, 1);
        nmi_edge(1'b1, 0);
        wr(eirq_pkg::OFS_SYSCTL, 16'h0001);
        nmi_edge(1'b0, 0);
        nmi_edge(1'b1, 1);
    endtask
    // interrupt status, mask, clear and peripheral requests
    task automatic t_irq;
        chk(irq_out, 1'b0);
        wr(eirq_pkg::OFS_INT_MASK, 16'h00FF);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1'b1);
        wr(eirq_pkg::OFS_INT_STATUS, 16'h00FF);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1'b0);
        rchk(eirq_pkg::OFS_INT_STATUS, 16'h0000);
        @(posedge clk_in);
        periph_flag_in <= 4'hA;
        periph_en_in   <= 4'h6;
        repeat (2) @(posedge clk_in);
        chk(periph_req_out, 4'h2);
    endtask

    initial
    begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs;
        t_sense;
        t_exc;
        t_nmi;
        t_irq;
        tally_and_finish;
    end
    initial
    begin
        #(25 * 5000);
        n_errors++;
        tally_and_finish;
    end
endmodule
